// [pkg/iod_pkg.sv]
package iod_pkg;

    // Data-space layout
    localparam logic [15:0] IOD_IO_OFFSET = 16'h0020;
    localparam logic [15:0] IOD_STD_FIRST = 16'h0020;
    localparam logic [15:0] IOD_STD_LAST = 16'h005f;
    localparam logic [15:0] IOD_EXT_FIRST = 16'h0060;
    localparam logic [15:0] IOD_EXT_LAST = 16'h00ff;
    localparam logic [15:0] IOD_SRAM_NORMAL = 16'h0100;
    localparam logic [15:0] IOD_SRAM_COMPAT = 16'h0060;
    localparam logic [5:0] IOD_BIT_LAST_IO = 6'h1f;

    // Block-owned register locations
    localparam logic [7:0] IOD_STATUS_IDX = 8'h1e;
    localparam logic [15:0] IOD_XCTRL_A_ADDR = 16'h006d;
    localparam logic [15:0] IOD_XCTRL_B_ADDR = 16'h006c;

    // Reset values
    localparam logic [7:0] IOD_STATUS_RST = 8'h00;
    localparam logic [7:0] IOD_XCTRL_A_RST = 8'h00;
    localparam logic [7:0] IOD_XCTRL_B_RST = 8'h00;

    // Field positions in the two external memory control registers
    localparam int IOD_XA_WAITL_LSB = 0;
    localparam int IOD_XA_WAITU_LSB = 2;
    localparam int IOD_XA_SECT_LSB = 4;
    localparam int IOD_XB_MASK_LSB = 0;
    localparam int IOD_XB_KEEP_BIT = 7;

    typedef enum logic [2:0] {
        OP_LOAD = 3'h0,
        OP_STORE = 3'h1,
        OP_IN = 3'h2,
        OP_OUT = 3'h3,
        OP_BIT_SET = 3'h4,
        OP_BIT_CLEAR = 3'h5,
        OP_SKIP_ONE = 3'h6,
        OP_SKIP_ZERO = 3'h7
    } iod_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WRITE = 2'b10
    } iod_state_t;

    typedef struct packed {
        logic valid;
        iod_op_t op;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [2:0] bitSel;
    } iod_req_t;

    typedef struct packed {
        logic done;
        logic refused;
        logic skip;
        logic [7:0] rdata;
    } iod_rsp_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] index;
        logic [7:0] wdata;
    } iod_periph_t;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } iod_sram_t;

    typedef struct packed {
        logic [1:0] waitLower;
        logic [1:0] waitUpper;
        logic [2:0] sectorLimit;
        logic keeperOn;
        logic [2:0] highMask;
    } iod_xmem_t;

endpackage

// [hdl/io_space_access_decoder.sv]
`timescale 1ns/1ns
// Operation
// - Bit set and bit clear reach only I/O addresses 0 to 1F.
// - Skip-if-one and skip-if-zero test one bit of a low I/O register.
// - In and out transfers use I/O addresses 0 to 3F only.
// - A standard I/O register sits at its I/O address plus 20 in data space.
// - Loads and stores reach every I/O and peripheral location.
// - Extended window 60 to FF answers only to loads and stores.
// - In legacy mode the extended range becomes plain SRAM.
// - Flag bits clear on a written one and ignore a written zero.
// - Bit set and bit clear read the whole register and write all bits back.
// - Both memory control registers live in the extended window only.
// - Legacy mode offers wait codes 00 and 01, no sectors, no keeper.
// - Data space holds 32 working, 64 standard and 160 extended locations.
module io_space_access_decoder #(
    parameter logic [223:0] ASSIGNED_MAP = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic compatFuse,
    input wire logic compatWaitSel,
    input wire logic [7:0] flagSet,
    input wire iod_pkg::iod_req_t req,
    output logic reqReady,
    output iod_pkg::iod_rsp_t rsp,
    output iod_pkg::iod_periph_t periph,
    input wire logic [7:0] periphRdata,
    output iod_pkg::iod_sram_t sram,
    input wire logic [7:0] sramRdata,
    output iod_pkg::iod_xmem_t xmemCfg,
    output logic [7:0] statusFlags
);
    import iod_pkg::*;

    iod_state_t state_reg;
    iod_state_t state_next;
    logic compatMeta_reg;
    logic compatSync_reg;
    logic [7:0] status_reg;
    logic [7:0] xctrlA_reg;
    logic [7:0] xctrlB_reg;
    logic [7:0] heldIdx_reg;
    logic [7:0] heldData_reg;
    logic heldStatus_reg;
    logic heldPeriph_reg;
    iod_rsp_t rsp_reg;
    iod_xmem_t xmem_reg;

    logic ioForm, bitForm, rmwOp, isWrite, ioRange, legal, take;
    logic isStd, isExt, isSram, hitStatus, hitXa, hitXb, hitPeriph;
    logic [15:0] dataAddr;
    logic [7:0] regIdx, readVal, bitMask, rmwData;
    logic statusWr;
    logic [7:0] statusWdata;

    // Legacy fuse is a pin level, so it crosses two flops first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compatMeta_reg <= 1'b0;
            compatSync_reg <= 1'b0;
        end else begin
            compatMeta_reg <= compatFuse;
            compatSync_reg <= compatMeta_reg;
        end
    end

    // Address decode
    always_comb begin
        ioForm = req.op inside {OP_IN, OP_OUT, OP_BIT_SET, OP_BIT_CLEAR,
                                OP_SKIP_ONE, OP_SKIP_ZERO};
        bitForm = req.op inside {OP_BIT_SET, OP_BIT_CLEAR,
                                 OP_SKIP_ONE, OP_SKIP_ZERO};
        rmwOp = req.op inside {OP_BIT_SET, OP_BIT_CLEAR};
        isWrite = req.op inside {OP_STORE, OP_OUT};
        ioRange = req.addr[15:6] == 10'h000;
        dataAddr = ioForm ? {10'h000, req.addr[5:0]} + IOD_IO_OFFSET
                          : req.addr;
        isStd = dataAddr >= IOD_STD_FIRST && dataAddr <= IOD_STD_LAST;
        isExt = !compatSync_reg && dataAddr >= IOD_EXT_FIRST
                && dataAddr <= IOD_EXT_LAST;
        isSram = dataAddr >= (compatSync_reg ? IOD_SRAM_COMPAT
                                             : IOD_SRAM_NORMAL);
        legal = ioForm ? (ioRange && (!bitForm
                          || req.addr[5:0] <= IOD_BIT_LAST_IO))
                       : (isStd || isExt || isSram);
        regIdx = 8'(dataAddr - IOD_IO_OFFSET);
        hitStatus = isStd && regIdx == IOD_STATUS_IDX;
        hitXa = isExt && dataAddr == IOD_XCTRL_A_ADDR;
        hitXb = isExt && dataAddr == IOD_XCTRL_B_ADDR;
        hitPeriph = (isStd || isExt) && !hitStatus && !hitXa && !hitXb
                    && ASSIGNED_MAP[regIdx];
    end

    // Read mux; working-register range and holes read zero
    always_comb begin
        if (hitStatus) begin
            readVal = status_reg;
        end else if (hitXa) begin
            readVal = xctrlA_reg;
        end else if (hitXb) begin
            readVal = xctrlB_reg;
        end else if (hitPeriph) begin
            readVal = periphRdata;
        end else if (isSram) begin
            readVal = sramRdata;
        end else begin
            readVal = 8'h00;
        end
        bitMask = 8'h01 << req.bitSel;
        rmwData = (req.op == OP_BIT_SET) ? (readVal | bitMask)
                                         : (readVal & ~bitMask);
    end

    assign take = req.valid && state_reg == ST_IDLE;
    assign reqReady = state_reg == ST_IDLE;

    // Peripheral strobes; the write-back cycle reuses the held index
    always_comb begin
        periph = '0;
        if (state_reg == ST_WRITE) begin
            periph.wr = heldPeriph_reg;
            periph.index = heldIdx_reg;
            periph.wdata = heldData_reg;
        end else begin
            periph.rd = take && legal && hitPeriph && !isWrite;
            periph.wr = take && legal && hitPeriph && isWrite;
            periph.index = regIdx;
            periph.wdata = req.wdata;
        end
    end

    // SRAM side, including the legacy extended range
    always_comb begin
        sram.sel = take && legal && isSram && !ioForm;
        sram.wr = isWrite;
        sram.addr = dataAddr;
        sram.wdata = req.wdata;
    end

    // Status flag write source: direct store or bit write-back
    always_comb begin
        statusWr = 1'b0;
        statusWdata = 8'h00;
        if (state_reg == ST_WRITE) begin
            statusWr = heldStatus_reg;
            statusWdata = heldData_reg;
        end else if (take && legal && hitStatus && isWrite) begin
            statusWr = 1'b1;
            statusWdata = req.wdata;
        end
    end

    // write one clears
    // A new event in the clearing cycle survives: set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= IOD_STATUS_RST;
        end else begin
            status_reg <= (status_reg & ~(statusWr ? statusWdata : 8'h00))
                          | flagSet;
        end
    end

    // Memory control registers; unreachable while legacy mode holds
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xctrlA_reg <= IOD_XCTRL_A_RST;
            xctrlB_reg <= IOD_XCTRL_B_RST;
        end else if (take && legal && isWrite) begin
            if (hitXa) begin
                xctrlA_reg <= req.wdata;
            end
            if (hitXb) begin
                xctrlB_reg <= req.wdata;
            end
        end
    end

    // legacy restrictions
    // Registered so the interface never sees a decode glitch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xmem_reg <= '0;
        end else if (compatSync_reg) begin
            xmem_reg.waitLower <= {1'b0, compatWaitSel};
            xmem_reg.waitUpper <= {1'b0, compatWaitSel};
            xmem_reg.sectorLimit <= 3'h0;
            xmem_reg.keeperOn <= 1'b0;
            xmem_reg.highMask <= 3'h0;
        end else begin
            xmem_reg.waitLower <= xctrlA_reg[IOD_XA_WAITL_LSB +: 2];
            xmem_reg.waitUpper <= xctrlA_reg[IOD_XA_WAITU_LSB +: 2];
            xmem_reg.sectorLimit <= xctrlA_reg[IOD_XA_SECT_LSB +: 3];
            xmem_reg.keeperOn <= xctrlB_reg[IOD_XB_KEEP_BIT];
            xmem_reg.highMask <= xctrlB_reg[IOD_XB_MASK_LSB +: 3];
        end
    end

    // Sequencer: bit set and clear take a second cycle to write back
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && legal && rmwOp) begin
                    state_next = ST_WRITE;
                end
            end
            ST_WRITE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Write-back context, caught on every accepted request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            heldIdx_reg <= 8'h00;
            heldData_reg <= 8'h00;
            heldStatus_reg <= 1'b0;
            heldPeriph_reg <= 1'b0;
        end else if (take) begin
            heldIdx_reg <= regIdx;
            heldData_reg <= rmwData;
            heldStatus_reg <= legal && rmwOp && hitStatus;
            heldPeriph_reg <= legal && rmwOp && hitPeriph;
        end
    end

    // Answer register: one-cycle done pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= '0;
            if (state_reg == ST_WRITE) begin
                rsp_reg.done <= 1'b1;
            end else if (take && !(legal && rmwOp)) begin
                rsp_reg.done <= 1'b1;
                rsp_reg.refused <= !legal;
                rsp_reg.rdata <= (legal && !isWrite) ? readVal : 8'h00;
                rsp_reg.skip <= legal
                    && req.op inside {OP_SKIP_ONE, OP_SKIP_ZERO}
                    && (readVal[req.bitSel] == (req.op == OP_SKIP_ONE));
            end
        end
    end

    assign rsp = rsp_reg;
    assign xmemCfg = xmem_reg;
    assign statusFlags = status_reg;

    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_bit_range: assert property (
        take && rmwOp && req.addr[5:0] > IOD_BIT_LAST_IO
        |-> !periph.rd ##1 rsp.done && rsp.refused && !periph.wr)
        else $error("bit op above low range not refused");
    chk_skip_result: assert property (
        take && legal && req.op == OP_SKIP_ONE
        |=> rsp.done && rsp.skip == $past(readVal[req.bitSel]))
        else $error("skip result wrong");
    chk_io_window: assert property (
        take && ioForm && !ioRange |=> rsp.done && rsp.refused)
        else $error("io form outside window accepted");
    chk_io_offset: assert property (
        take && ioForm && legal && hitPeriph
        |-> periph.index == {2'b00, req.addr[5:0]})
        else $error("io address offset wrong");
    chk_ext_loads: assert property (
        take && ioForm |-> !(periph.rd || periph.wr) || periph.index < 8'h40)
        else $error("io form reached extended window");
    chk_compat_sram: assert property (
        take && compatSync_reg && !ioForm && req.addr >= IOD_EXT_FIRST
        && req.addr <= IOD_EXT_LAST |-> sram.sel && !periph.rd && !periph.wr)
        else $error("legacy extended range not sram");
    chk_flag_clear: assert property (
        take && legal && hitStatus && isWrite
        |=> status_reg == (($past(status_reg) & ~$past(req.wdata))
                           | $past(flagSet)))
        else $error("flag clear wrong");
    chk_rmw_back: assert property (
        take && legal && req.op == OP_BIT_SET && hitPeriph
        |-> periph.rd ##1 periph.wr && !rsp.done
            && periph.wdata == ($past(readVal) | $past(bitMask))
            ##1 rsp.done && !periph.wr)
        else $error("bit write-back wrong");
    chk_legacy_xmem: assert property (
        compatSync_reg |=> !xmemCfg.keeperOn && xmemCfg.sectorLimit == 3'h0
            && !xmemCfg.waitLower[1] && !xmemCfg.waitUpper[1])
        else $error("legacy memory options leaked");
    chk_load_path: assert property (
        take && legal && hitPeriph && req.op == OP_LOAD
        |-> periph.rd ##1 rsp.done && rsp.rdata == $past(periphRdata))
        else $error("load path wrong");
    chk_hole_zero: assert property (
        take && (isStd || isExt) && !hitStatus && !hitXa && !hitXb
        && !ASSIGNED_MAP[regIdx]
        |-> !periph.rd && !periph.wr ##1 rsp.rdata == 8'h00)
        else $error("unassigned location active");

    cov_bit_set: cover property (take && legal && req.op == OP_BIT_SET);
    cov_skip_taken: cover property (rsp.done && rsp.skip);
    cov_legacy_sram: cover property (sram.sel && compatSync_reg);
    cov_flag_race: cover property (statusWr && |(flagSet & statusWdata));
endmodule

// [bench/iod_periph_model.sv]
`timescale 1ns/1ns
// Peripheral registers and data SRAM on the far side of the decoder
module iod_periph_model
    import iod_pkg::*;
(
    input wire logic clk,
    input wire iod_pkg::iod_periph_t periph,
    output logic [7:0] periphRdata,
    input wire iod_pkg::iod_sram_t sram,
    output logic [7:0] sramRdata
);
    logic [7:0] regs [0:223];
    logic [7:0] mem [0:511];
    logic [7:0] lastP;
    logic [7:0] lastS;

    // Known start pattern so the bench can predict every read
    initial begin
        for (int i = 0; i < 224; i++) begin
            regs[i] = 8'(i) ^ 8'ha5;
        end
        for (int i = 0; i < 512; i++) begin
            mem[i] = 8'h00;
        end
        lastP = 8'h00;
        lastS = 8'h00;
    end

    // Writes land at the edge; reads are answered in the same cycle
    always @(posedge clk) begin
        if (periph.wr && periph.index < 8'he0) begin
            regs[periph.index] <= periph.wdata;
        end
        if (sram.sel && sram.wr) begin
            mem[sram.addr[8:0]] <= sram.wdata;
        end
        if (periph.rd) begin
            lastP <= periphRdata;
        end
        if (sram.sel) begin
            lastS <= sramRdata;
        end
    end

    // Released lines show the inverse of the last value on them; after a single SRAM write the SRAM line shows the last read data again
    assign periphRdata = periph.rd ? regs[periph.index] : ~lastP;
    assign sramRdata = (sram.sel && !sram.wr) ? mem[sram.addr[8:0]] : ~lastS;
endmodule

// [bench/io_space_access_decoder_test.sv]
`timescale 1ns/1ns
module io_space_access_decoder_test;
    import iod_pkg::*;
    // Index 0x40 (data 0x60) left unassigned to exercise a hole
    localparam logic [223:0] HOLE_MAP = ~(224'h1 << 64);
    logic clk = 1'b0;
    logic rst_n, compatFuse, compatWaitSel, reqReady;
    logic [7:0] flagSet, periphRdata, sramRdata, statusFlags, gotData;
    logic gotRef, gotSkip, gotStrobe;
    iod_req_t req;
    iod_rsp_t rsp;
    iod_periph_t periph;
    iod_sram_t sram;
    iod_xmem_t xmemCfg;
    int bad_count = 0;
    int num_checks = 0;

    always #10 clk = ~clk;

    io_space_access_decoder #(.ASSIGNED_MAP(HOLE_MAP)) DUT (.clk(clk),
        .rst_n(rst_n), .compatFuse(compatFuse), .compatWaitSel(compatWaitSel),
        .flagSet(flagSet), .req(req), .reqReady(reqReady), .rsp(rsp),
        .periph(periph), .periphRdata(periphRdata), .sram(sram),
        .sramRdata(sramRdata), .xmemCfg(xmemCfg), .statusFlags(statusFlags));
    iod_periph_model PEER (.clk(clk), .periph(periph),
        .periphRdata(periphRdata), .sram(sram), .sramRdata(sramRdata));

    function automatic logic [7:0] pat(input logic [7:0] i);
        return i ^ 8'ha5;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One request held until taken, then wait for the answer pulse
    task automatic xfer(input iod_op_t op, input logic [15:0] a,
                        input logic [7:0] wd, input logic [2:0] bs);
        int n;
        @(posedge clk);
        req <= '{1'b1, op, a, wd, bs};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (reqReady !== 1'b1 && n < 8);
        if (reqReady !== 1'b1) begin
            bad_count++;
            summarize();
        end
        gotStrobe = periph.rd | periph.wr | sram.sel;
        @(posedge clk);
        req.valid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
            gotStrobe = gotStrobe | periph.rd | periph.wr | sram.sel;
        end while (rsp.done !== 1'b1 && n < 16);
        if (n >= 16) begin
            bad_count++;
            summarize();
        end
        gotData = rsp.rdata;
        gotRef = rsp.refused;
        gotSkip = rsp.skip;
    endtask

    task automatic t_std_io();
        xfer(OP_LOAD, 16'h0025, 8'h00, 3'h0);
        check(gotData, pat(8'h05));
        xfer(OP_IN, 16'h0005, 8'h00, 3'h0);
        check(gotData, pat(8'h05));
        xfer(OP_OUT, 16'h003f, 8'h3c, 3'h0);
        check(gotRef, 16'h0);
        xfer(OP_LOAD, 16'h005f, 8'h00, 3'h0);
        check(gotData, 8'h3c);
        xfer(OP_STORE, 16'h00ff, 8'hc3, 3'h0);
        xfer(OP_LOAD, 16'h00ff, 8'h00, 3'h0);
        check(gotData, 8'hc3);
        xfer(OP_STORE, 16'h0100, 8'h77, 3'h0);
        xfer(OP_LOAD, 16'h0100, 8'h00, 3'h0);
        check(gotData, 8'h77);
    endtask

    task automatic t_refuse();
        iod_op_t ops [8] = '{OP_IN, OP_OUT, OP_BIT_SET, OP_BIT_CLEAR,
                             OP_SKIP_ONE, OP_SKIP_ZERO, OP_LOAD, OP_STORE};
        logic [15:0] adr [8] = '{16'h0040, 16'h0040, 16'h0020, 16'h0020,
                                 16'h0020, 16'h0020, 16'h001f, 16'h001f};
        for (int i = 0; i < 8; i++) begin
            xfer(ops[i], adr[i], 8'hff, 3'h1);
            check({gotRef, gotStrobe, gotData}, 16'h200);
        end
    endtask

    task automatic t_bits();
        // Bit 2 starts clear, so a lost write-back shows
        xfer(OP_BIT_SET, 16'h001f, 8'h00, 3'h2);
        xfer(OP_LOAD, 16'h003f, 8'h00, 3'h0);
        check(gotData, pat(8'h1f) | 8'h04);
        xfer(OP_BIT_CLEAR, 16'h0000, 8'h00, 3'h0);
        xfer(OP_LOAD, 16'h0020, 8'h00, 3'h0);
        check(gotData, pat(8'h00) & 8'hfe);
        for (int b = 0; b < 8; b++) begin
            xfer(OP_SKIP_ONE, 16'h0007, 8'h00, 3'(b));
            check(gotSkip, pat(8'h07) >> b & 8'h01);
            xfer(OP_SKIP_ZERO, 16'h0007, 8'h00, 3'(b));
            check(gotSkip, ~pat(8'h07) >> b & 8'h01);
        end
    endtask

    task automatic t_status();
        @(posedge clk);
        flagSet <= 8'hff;
        @(posedge clk);
        flagSet <= 8'h00;
        repeat (2) @(negedge clk);
        check(statusFlags, 8'hff);
        xfer(OP_OUT, 16'h001e, 8'h0f, 3'h0);
        check(statusFlags, 8'hf0);
        xfer(OP_STORE, 16'h003e, 8'h00, 3'h0);
        xfer(OP_LOAD, 16'h003e, 8'h00, 3'h0);
        check(gotData, 8'hf0);
        xfer(OP_BIT_SET, 16'h001e, 8'h00, 3'h0);
        check(statusFlags, 8'h00);
    endtask

    task automatic t_xmem();
        // Reserved bits written as zero
        xfer(OP_STORE, 16'h006d, 8'h7b, 3'h0);
        xfer(OP_STORE, 16'h006c, 8'h85, 3'h0);
        // Config output lags the register write by one edge
        @(negedge clk);
        check(xmemCfg, iod_xmem_t'({2'h3, 2'h2, 3'h7, 1'b1, 3'h5}));
        xfer(OP_LOAD, 16'h006d, 8'h00, 3'h0);
        check(gotData, 8'h7b);
        // Legacy mode needs the two-stage sync plus one edge
        @(posedge clk);
        compatFuse <= 1'b1;
        compatWaitSel <= 1'b1;
        repeat (5) @(negedge clk);
        check(xmemCfg, iod_xmem_t'({2'h1, 2'h1, 3'h0, 1'b0, 3'h0}));
        xfer(OP_STORE, 16'h006d, 8'h5a, 3'h0);
        xfer(OP_LOAD, 16'h006d, 8'h00, 3'h0);
        check(gotData, 8'h5a);
        check(xmemCfg, iod_xmem_t'({2'h1, 2'h1, 3'h0, 1'b0, 3'h0}));
        xfer(OP_LOAD, 16'h00ff, 8'h00, 3'h0);
        check(gotData, 8'h00);
        @(posedge clk);
        compatWaitSel <= 1'b0;
        repeat (2) @(negedge clk);
        check(xmemCfg, 16'h0);
        @(posedge clk);
        compatFuse <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    task automatic t_hole();
        // Only read the hole; software never writes it
        xfer(OP_LOAD, 16'h0060, 8'h00, 3'h0);
        check({gotRef, gotStrobe, gotData}, 16'h000);
    endtask

    // Reset, then one task per area of behaviour
    initial begin
        req = '0;
        rst_n = 1'b0;
        compatFuse = 1'b0;
        compatWaitSel = 1'b0;
        flagSet = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
        check({reqReady, rsp}, 16'h800);
        check(xmemCfg, 16'h0);
        check(statusFlags, 16'h0);
        t_std_io();
        t_refuse();
        t_bits();
        t_status();
        t_xmem();
        t_hole();
        summarize();
    end
endmodule
